/* File: verilog/spc_pkg.sv */
package spc_pkg;
	// Control register field positions.
	localparam int CTL_ENABLE_BIT   = 0;
	localparam int CTL_OVR_RATE_LO  = 1;
	localparam int CTL_DOUT_RATE_HI = 2;
	localparam int CTL_COMPARE_BIT  = 3;
	localparam int CTL_IRQ_EN_BIT   = 4;
	localparam int CTL_PHASE_BIT    = 5;
	localparam int CTL_CLKSRC_BIT   = 6;
	localparam int CTL_MASTER_BIT   = 7;
	// Reset values.
	localparam logic [7:0] CTL_RESET   = 8'h00;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	// Byte length and FIFO shape.
	localparam int BYTE_BITS   = 8;
	localparam int FIFO_DEPTH  = 16;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// Master divider half periods for codes 00..11 (divide by 2, 4, 8, 16).
	localparam logic [3:0] HALF_DIV2  = 4'h1;
	localparam logic [3:0] HALF_DIV4  = 4'h2;
	localparam logic [3:0] HALF_DIV8  = 4'h4;
	localparam logic [3:0] HALF_DIV16 = 4'h8;
	// Transfer states, one-hot.
	typedef enum logic [3:0] {
		SPC_IDLE    = 4'b0001,
		SPC_XFER    = 4'b0010,
		SPC_COMPARE = 4'b0100,
		SPC_IGNORE  = 4'b1000
	} spc_state_type;
endpackage

/* File: verilog/spc_fifo.sv */
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides.
module spc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst,
	// Fill side.
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Drain side.
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [AW:0]      count_reg, count_next;
	logic             push, pop;

	// Full and empty come straight from the occupancy count.
	assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign push = i_in_valid && o_in_ready;
	assign pop  = o_out_valid && i_out_ready;

	// Pointer and count updates.
	always_comb begin
		wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
		rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
		count_next  = count_reg;
		if (push && !pop) begin
			count_next = (AW+1)'(count_reg + 1'b1);
		end else if (pop && !push) begin
			count_next = (AW+1)'(count_reg - 1'b1);
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	// Storage has no reset; only written words are ever read.
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end
endmodule // spc_fifo

/* File: verilog/spc_port.sv */
`timescale 1ns/1ps
module spc_port
	import spc_pkg::*;
(
	// Clock and reset.
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	// Control register write port and readback.
	input  wire logic        i_ctl_wr,
	input  wire logic [7:0]  i_ctl_wdata,
	output logic [7:0]       o_ctl_rdata,
	// Compare value register.
	input  wire logic        i_cmp_wr,
	input  wire logic [7:0]  i_cmp_wdata,
	// Transmit byte write (master starts, slave preloads).
	input  wire logic        i_tx_wr,
	input  wire logic [7:0]  i_tx_wdata,
	// Receive buffer read side.
	input  wire logic        i_rx_rd,
	output logic [7:0]       o_rx_data,
	output logic             o_rx_avail,
	// Receive stream out of the FIFO.
	output logic             o_fifo_valid,
	input  wire logic        i_fifo_ready,
	output logic [7:0]       o_fifo_data,
	// Events.
	output logic             o_receive_interrupt_request,
	output logic             o_stop_wake_recovery,
	output logic             o_busy,
	// Pins.
	input  wire logic        i_timer_zero_output,
	input  wire logic        i_serial_in_pin,
	input  wire logic        i_slave_select_n,
	input  wire logic        i_serial_clock_pin,
	output logic             o_serial_clock_pin,
	output logic             o_serial_clock_pin_oe,
	output logic             o_serial_out_pin,
	output logic             o_serial_out_pin_oe
);
	import spc_pkg::*;

	// Receive FIFO fed by the shifter alongside the buffer the CPU reads.
	// A full FIFO drops the new byte while the receive buffer still takes it, so
	// software that only polls the buffer always sees the newest byte.
	logic       q_valid, q_ready, q_out_valid;
	logic [7:0] q_data;

	spc_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_sys_clk   (i_sys_clk),
		.i_rst       (i_rst),
		.i_in_valid  (q_valid),
		.o_in_ready  (q_ready),
		.i_in_data   (q_data),
		.o_out_valid (q_out_valid),
		.i_out_ready (i_fifo_ready),
		.o_out_data  (o_fifo_data)
	);
	assign o_fifo_valid = q_out_valid;

	// The FIFO ready is deliberately not fed back: in slave mode the shift clock
	// belongs to the far side, so a stalled drain must never stall the shifter.
	// State.
	spc_state_type state_reg, state_next;
	logic [7:0] ctl_reg, ctl_next, cmp_reg, cmp_next;
	logic [7:0] shift_reg, shift_next, receive_buffer_reg, receive_buffer_next;
	logic [2:0] bit_reg, bit_next;
	logic [3:0] div_reg, div_next;
	logic       sck_reg, sck_next, dout_reg, dout_next;
	logic       avail_reg, avail_next, ovr_reg, ovr_next;
	logic       irq_reg, irq_next, wake_reg, wake_next, cmp_first_reg, cmp_first_next;
	logic       clk_prev_reg, clk_prev_next, tmr_prev_reg, tmr_prev_next;
	logic       dout_en_reg, dout_en_next;

	// Decoded control fields.
	// Bits 1 and 2 hold a rate in master mode, a flag and an output mute as slave.
	logic enable, master, compare_mode, phase, irq_en, dout_off;
	logic [3:0] half_div;
	assign enable       = ctl_reg[CTL_ENABLE_BIT];
	assign master       = ctl_reg[CTL_MASTER_BIT];
	assign compare_mode = ctl_reg[CTL_COMPARE_BIT] && !master;
	assign phase        = ctl_reg[CTL_PHASE_BIT];
	assign irq_en       = ctl_reg[CTL_IRQ_EN_BIT];
	assign dout_off     = ctl_reg[CTL_DOUT_RATE_HI];

	// Rate code to half-period of the divided system clock.
	function automatic logic [3:0] rate_half(input logic [1:0] code);
		case (code)
			2'b00:   rate_half = HALF_DIV2;
			2'b01:   rate_half = HALF_DIV4;
			2'b10:   rate_half = HALF_DIV8;
			default: rate_half = HALF_DIV16;
		endcase
	endfunction
	assign half_div = rate_half(ctl_reg[CTL_DOUT_RATE_HI:CTL_OVR_RATE_LO]);

	// Edge detection of the active shift clock. Master uses its own clock or the timer.
	// The previous level is tracked in every state, idle too, so a select that arrives
	// with the clock already at its idle level never counts as an edge.
	logic clk_now, rise, fall, sample_edge, drive_edge, tmr_tick, sel;
	assign sel      = !i_slave_select_n;
	assign tmr_tick = i_timer_zero_output && !tmr_prev_reg;
	assign clk_now  = master ? sck_reg : i_serial_clock_pin;
	assign rise     = clk_now && !clk_prev_reg;
	assign fall     = !clk_now && clk_prev_reg;
	assign sample_edge = phase ? fall : rise;
	assign drive_edge  = phase ? rise : fall;

	// Next-state logic for the whole port.
	always_comb begin
		logic [7:0] rx_byte;
		logic       tick;
		rx_byte        = {shift_reg[6:0], i_serial_in_pin};
		tick           = 1'b0;
		state_next     = state_reg;
		ctl_next       = ctl_reg;
		cmp_next       = i_cmp_wr ? i_cmp_wdata : cmp_reg;
		shift_next     = shift_reg;
		receive_buffer_next     = receive_buffer_reg;
		bit_next       = bit_reg;
		div_next       = div_reg;
		sck_next       = sck_reg;
		dout_next      = dout_reg;
		avail_next     = avail_reg;
		ovr_next       = ovr_reg;
		irq_next       = 1'b0;
		wake_next      = 1'b0;
		cmp_first_next = cmp_first_reg;
		dout_en_next   = dout_en_reg;
		clk_prev_next  = clk_now;
		tmr_prev_next  = i_timer_zero_output;
		q_valid        = 1'b0;
		q_data         = rx_byte;
		// Software writes; overrun only ever cleared by writing zero.
		if (i_ctl_wr) begin
			// The low rate bit is stored as written, so a write that turns the port
			// into a master keeps its rate; as slave the readback shows the overrun
			// flag in that place instead.
			ctl_next = i_ctl_wdata;
			if (!master && !i_ctl_wdata[CTL_OVR_RATE_LO]) begin
				ovr_next = 1'b0;
			end
		end
		if (i_rx_rd) begin
			avail_next = 1'b0;
		end
		if (!enable) begin
			state_next   = SPC_IDLE;
			dout_en_next = 1'b0;
			sck_next     = 1'b0;
		end else begin
			case (state_reg)
				SPC_IDLE: begin
					bit_next = '0;
					div_next = '0;
					// A slave byte may be preloaded while deselected; without this the
					// first bits out would be whatever the last transfer left behind.
					if (!master && i_tx_wr) begin
						shift_next = i_tx_wdata;
					end
					if (master && i_tx_wr) begin
						shift_next   = i_tx_wdata;
						dout_next    = i_tx_wdata[7];
						dout_en_next = 1'b1;
						state_next   = SPC_XFER;
					end else if (!master && sel) begin
						cmp_first_next = compare_mode;
						dout_en_next   = !compare_mode && !dout_off;
						dout_next  = i_tx_wr ? i_tx_wdata[7] : shift_reg[7];
						state_next = compare_mode ? SPC_COMPARE : SPC_XFER;
					end
				end
				SPC_XFER, SPC_COMPARE: begin
					// Master clock: divided system clock or timer output.
					// The timer source ticks once per rising edge of the timer output.
					if (master) begin
						tick = ctl_reg[CTL_CLKSRC_BIT] ? tmr_tick : 1'b1;
						if (tick) begin
							div_next = 4'(div_reg + 1'b1);
							if (4'(div_reg + 1'b1) >= half_div) begin
								div_next = '0;
								sck_next = !sck_reg;
							end
						end
					end else if (!sel) begin
						// Deselect ends the frame at once; a part byte is dropped, since a
						// cut frame carries nothing a receiver could trust.
						state_next   = SPC_IDLE;
						dout_en_next = 1'b0;
					end
					// Sampling and driving are opposite edges and never meet in one cycle.
					if (sample_edge && (master || sel)) begin
						shift_next = rx_byte;
						bit_next   = 3'(bit_reg + 1'b1);
						if (bit_reg == BIT_LAST) begin
							if (state_reg == SPC_COMPARE) begin
								// The compare byte never reaches the buffer, FIFO or interrupt.
								if (rx_byte == cmp_reg) begin
									wake_next    = 1'b1;
									dout_en_next = !dout_off;
									state_next   = SPC_XFER;
								end else begin
									state_next   = SPC_IGNORE;
									dout_en_next = 1'b0;
								end
							end else begin
								receive_buffer_next = rx_byte;
								avail_next = 1'b1;
								irq_next   = irq_en;
								q_valid    = 1'b1;
								// A read in the same cycle as the new byte still counts as in time.
								if (avail_reg && !i_rx_rd && !master) begin
									ovr_next = 1'b1;
								end
								if (master) begin
									state_next   = SPC_IDLE;
									dout_en_next = 1'b0;
									sck_next     = 1'b0;
								end
							end
						end
					end else if (drive_edge && (master || sel)) begin
						dout_next = shift_reg[7];
					end
					if (master && i_tx_wr && state_reg == SPC_XFER) begin
						shift_next = i_tx_wdata;
					end
				end
				SPC_IGNORE: begin
					// A switch to master also leaves, so the port cannot lock up here.
					if (!sel || master) begin
						state_next = SPC_IDLE;
					end
				end
				default: state_next = SPC_IDLE;
			endcase
		end
	end

	// Registers only; every decision is taken in the process above.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg     <= SPC_IDLE;
			ctl_reg       <= CTL_RESET;
			cmp_reg       <= BYTE_RESET;
			shift_reg     <= BYTE_RESET;
			receive_buffer_reg     <= BYTE_RESET;
			bit_reg       <= '0;
			div_reg       <= '0;
			sck_reg       <= 1'b0;
			dout_reg      <= 1'b0;
			avail_reg     <= 1'b0;
			ovr_reg       <= 1'b0;
			irq_reg       <= 1'b0;
			wake_reg      <= 1'b0;
			cmp_first_reg <= 1'b0;
			clk_prev_reg  <= 1'b0;
			tmr_prev_reg  <= 1'b0;
			dout_en_reg   <= 1'b0;
		end else begin
			state_reg     <= state_next;
			ctl_reg       <= ctl_next;
			cmp_reg       <= cmp_next;
			shift_reg     <= shift_next;
			receive_buffer_reg     <= receive_buffer_next;
			bit_reg       <= bit_next;
			div_reg       <= div_next;
			sck_reg       <= sck_next;
			dout_reg      <= dout_next;
			avail_reg     <= avail_next;
			ovr_reg       <= ovr_next;
			irq_reg       <= irq_next;
			wake_reg      <= wake_next;
			cmp_first_reg <= cmp_first_next;
			clk_prev_reg  <= clk_prev_next;
			tmr_prev_reg  <= tmr_prev_next;
			dout_en_reg   <= dout_en_next;
		end
	end

	// Outputs. Slave select is never driven by this port; software owns it.
	// Slave readback puts the live flags where the rate bit and interrupt enable sit.
	// The clock pin is driven only by an enabled master, so a slave never fights it.
	assign o_ctl_rdata = master ? ctl_reg
		: {ctl_reg[7:5], avail_reg, ctl_reg[3:2], ovr_reg, ctl_reg[0]};
	assign o_rx_data   = receive_buffer_reg;
	assign o_rx_avail  = avail_reg;
	assign o_receive_interrupt_request = irq_reg;
	assign o_stop_wake_recovery = wake_reg;
	assign o_busy      = (state_reg != SPC_IDLE);
	assign o_serial_clock_pin    = sck_reg;
	assign o_serial_clock_pin_oe = master && enable;
	assign o_serial_out_pin      = dout_reg;
	assign o_serial_out_pin_oe   = dout_en_reg && enable;

	// The compare byte must never reach the buffer or the interrupt.
	cmp_no_irq_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_reg == SPC_COMPARE |=> !irq_reg)
		else $error("Interrupt raised by a compare byte.");
	mismatch_silent_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_reg == SPC_IGNORE |-> !o_serial_out_pin_oe)
		else $error("Output driven after a compare mismatch.");
	disabled_quiet_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!enable |-> !o_serial_out_pin_oe && !o_serial_clock_pin_oe)
		else $error("Pins driven while the port is disabled.");
	slave_clk_in_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!master |-> !o_serial_clock_pin_oe)
		else $error("Slave drives the serial clock.");
	avail_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_rx_rd && !q_valid |=> !o_rx_avail)
		else $error("Receive flag not cleared by a buffer read.");
	irq_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_receive_interrupt_request |-> $past(irq_en) && o_rx_avail)
		else $error("Interrupt without enable or flag.");
	ovr_sticky_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$fell(ovr_reg) |-> $past(i_ctl_wr) && !$past(i_ctl_wdata[CTL_OVR_RATE_LO]))
		else $error("Overrun cleared without a zero write.");
	wake_match_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_stop_wake_recovery |-> $past(state_reg) == SPC_COMPARE && state_reg == SPC_XFER)
		else $error("Wake pulse without a compare match.");

	// Event pulses last one cycle, and every finished byte outside a compare lands where software looks.
	irq_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_receive_interrupt_request |=> !o_receive_interrupt_request)
		else $error("Interrupt request held longer than one cycle.");
	wake_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_stop_wake_recovery |=> !o_stop_wake_recovery)
		else $error("Wake pulse held longer than one cycle.");
	byte_avail_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		q_valid |=> o_rx_avail)
		else $error("Finished byte did not set the receive flag.");
	overrun_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		q_valid && avail_reg && !i_rx_rd && !master |=> ovr_reg)
		else $error("Unread buffer overwritten without overrun.");
	cmp_no_push_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_reg == SPC_COMPARE |-> !q_valid)
		else $error("Compare byte pushed into the receive stream.");
	ignore_no_push_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_reg == SPC_IGNORE |-> !q_valid)
		else $error("Data taken after a compare mismatch.");
	push_in_xfer_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		q_valid |-> state_reg == SPC_XFER)
		else $error("Byte pushed outside a transfer.");
	master_done_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		master && q_valid |=> !o_busy)
		else $error("Master still busy after its byte completed.");
endmodule // spc_port

/* File: sim/spc_far_end.sv */
`timescale 1ns/1ps
// Far-side model: an external master on the slave path, or a slave picked
// by a general I/O line when the port is master. The slave role keeps phase 0 only.
module spc_far_end (
	// Clock.
	input  wire logic i_sys_clk,
	// Lines toward the port.
	output logic      o_sck,
	output logic      o_sel_n,
	output logic      o_data,
	input  wire logic i_port_sck,
	input  wire logic i_port_dout,
	input  wire logic i_port_dout_oe
);
	localparam int HALF = 4;
	logic [7:0] slv_tx, slv_rx;
	logic       slv_on, sck_q;
	int         gap_cnt, edge_gap, oe_bits;

	initial begin
		o_sck = 1'b0;
		o_sel_n = 1'b1;
		o_data = 1'b0;
		slv_on = 1'b0;
		sck_q = 1'b0;
		gap_cnt = 0;
		edge_gap = 0;
		oe_bits = 0;
		slv_tx = 8'h00;
		slv_rx = 8'h00;
	end

	// Master role: select first, clock idles at the phase level.
	task automatic sel(input logic ph);
		o_sck = ph;
		o_sel_n = 1'b0;
		repeat (HALF) @(negedge i_sys_clk);
	endtask

	// Released data shows the inverse of the last bit, never a stale value.
	task automatic desel();
		repeat (HALF) @(negedge i_sys_clk);
		o_sel_n = 1'b1;
		o_data = ~o_data;
	endtask

	// One byte, MSB first; the port sees the clock only as an input here.
	task automatic master_byte(input logic ph, input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_data = tx[i];
			repeat (HALF) @(negedge i_sys_clk);
			o_sck = ~ph;
			rx[i] = i_port_dout_oe ? i_port_dout : 1'bx;
			oe_bits = oe_bits + int'(i_port_dout_oe === 1'b1);
			repeat (HALF) @(negedge i_sys_clk);
			o_sck = ph;
		end
	endtask

	// Slave role: first bit waits on the line before the first clock.
	task automatic slave_load(input logic [7:0] b);
		o_data = b[7];
		slv_tx = {b[6:0], ~b[0]};
		slv_on = 1'b1;
	endtask

	task automatic slave_stop();
		slv_on = 1'b0;
		o_data = ~o_data;
	endtask

	// Slave shifts on the master's clock and measures its period in system cycles.
	always @(negedge i_sys_clk) begin
		sck_q <= i_port_sck;
		gap_cnt <= gap_cnt + 1;
		if (slv_on && i_port_sck && !sck_q) begin
			slv_rx <= {slv_rx[6:0], i_port_dout};
			edge_gap <= gap_cnt;
			gap_cnt <= 1;
		end
		if (slv_on && !i_port_sck && sck_q) begin
			o_data <= slv_tx[7];
			slv_tx <= {slv_tx[6:0], ~slv_tx[7]};
		end
	end
endmodule // spc_far_end

/* File: sim/test_spi_master_slave_compare.sv */
`timescale 1ns/1ps
// Self-checking bench for the serial port, with a far-side model and FIFO stalls.
module test_spi_master_slave_compare;
	import spc_pkg::*;
	logic       i_sys_clk, i_rst, i_ctl_wr, i_cmp_wr, i_tx_wr, i_rx_rd, i_fifo_ready;
	logic [7:0] i_ctl_wdata, i_cmp_wdata, i_tx_wdata, o_ctl_rdata, o_rx_data, o_fifo_data;
	logic       o_fifo_valid, o_receive_interrupt_request, o_stop_wake_recovery, o_busy;
	logic       i_timer_zero_output, o_serial_clock_pin, o_serial_clock_pin_oe;
	logic       o_serial_out_pin, o_serial_out_pin_oe, far_sck, far_sel_n, far_data;
	wire        sck_line = o_serial_clock_pin_oe ? o_serial_clock_pin : far_sck;
	int         mismatches, checks, cyc, irq_cnt, wake_cnt, seed;
	logic       oe_seen;
	logic [7:0] a, b, got, q[$];

	spc_port u_spc_port (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ctl_wr(i_ctl_wr),
		.i_ctl_wdata(i_ctl_wdata), .o_ctl_rdata(o_ctl_rdata), .i_cmp_wr(i_cmp_wr),
		.i_cmp_wdata(i_cmp_wdata), .i_tx_wr(i_tx_wr), .i_tx_wdata(i_tx_wdata),
		.i_rx_rd(i_rx_rd), .o_rx_data(o_rx_data), .o_rx_avail(), .o_fifo_valid(o_fifo_valid),
		.i_fifo_ready(i_fifo_ready), .o_fifo_data(o_fifo_data),
		.o_receive_interrupt_request(o_receive_interrupt_request),
		.o_stop_wake_recovery(o_stop_wake_recovery), .o_busy(o_busy),
		.i_timer_zero_output(i_timer_zero_output), .i_serial_in_pin(far_data),
		.i_slave_select_n(far_sel_n), .i_serial_clock_pin(sck_line),
		.o_serial_clock_pin(o_serial_clock_pin), .o_serial_clock_pin_oe(o_serial_clock_pin_oe),
		.o_serial_out_pin(o_serial_out_pin), .o_serial_out_pin_oe(o_serial_out_pin_oe));

	spc_far_end u_spc_far_end (.i_sys_clk(i_sys_clk), .o_sck(far_sck), .o_sel_n(far_sel_n),
		.o_data(far_data), .i_port_sck(sck_line), .i_port_dout(o_serial_out_pin),
		.i_port_dout_oe(o_serial_out_pin_oe));

	// 200 MHz clock.
	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	// Timer output toggles every cycle, so it rises once every two clocks.
	always @(negedge i_sys_clk) begin
		i_timer_zero_output <= !i_timer_zero_output;
	end

	// Event counters and the hang limit, well above the few thousand cycles needed.
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		irq_cnt <= irq_cnt + int'(o_receive_interrupt_request === 1'b1);
		wake_cnt <= wake_cnt + int'(o_stop_wake_recovery === 1'b1);
		oe_seen <= oe_seen | (o_serial_out_pin_oe === 1'b1);
		if (cyc == 60000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Control word from its fields; the rate bits double as flags in slave mode.
	function automatic logic [7:0] ctl_word(input logic en, m, ph, ie, cm, input logic [1:0] r);
		ctl_word = 8'h00;
		ctl_word[CTL_ENABLE_BIT] = en;
		ctl_word[CTL_MASTER_BIT] = m;
		ctl_word[CTL_PHASE_BIT] = ph;
		ctl_word[CTL_IRQ_EN_BIT] = ie;
		ctl_word[CTL_COMPARE_BIT] = cm;
		ctl_word[CTL_OVR_RATE_LO] = r[0];
		ctl_word[CTL_DOUT_RATE_HI] = r[1];
	endfunction

	// One-cycle strobes, raised and dropped on falling edges.
	task automatic pulse(input int which, input logic [7:0] d);
		@(negedge i_sys_clk);
		i_ctl_wdata = d;
		i_cmp_wdata = d;
		i_tx_wdata = d;
		i_ctl_wr = (which == 0);
		i_cmp_wr = (which == 1);
		i_tx_wr = (which == 2);
		i_rx_rd = (which == 3);
		@(negedge i_sys_clk);
		{i_ctl_wr, i_cmp_wr, i_tx_wr, i_rx_rd} = 4'h0;
	endtask

	task automatic clr();
		@(negedge i_sys_clk);
		irq_cnt = 0;
		wake_cnt = 0;
		oe_seen = 1'b0;
	endtask

	task automatic wait_idle();
		repeat (2) @(negedge i_sys_clk);
		for (int n = 0; n < 2000 && o_busy !== 1'b0; n++)
			@(negedge i_sys_clk);
		repeat (2) @(negedge i_sys_clk);
	endtask

	initial begin
		{i_ctl_wr, i_cmp_wr, i_tx_wr, i_rx_rd, i_timer_zero_output} = 5'h00;
		{i_ctl_wdata, i_cmp_wdata, i_tx_wdata} = 24'h00_0000;
		{mismatches, checks, cyc, irq_cnt, wake_cnt} = '0;
		oe_seen = 1'b0;
		i_fifo_ready = 1'b1;
		seed = 62;
		i_rst = 1'b1;
		repeat (10) @(negedge i_sys_clk);
		i_rst = 1'b0;
		check("ctl after reset", o_ctl_rdata, CTL_RESET);
		// Disabled master: a load must not reach the data pin.
		clr();
		pulse(0, ctl_word(0, 1, 0, 1, 0, 2'h0));
		pulse(2, 8'hA5);
		repeat (40) @(negedge i_sys_clk);
		check("disabled out enable", {7'h0, oe_seen}, 8'h00);
		$display("test disabled done");
		// Master at every rate code; the interrupt enable follows the low rate bit.
		for (int r = 0; r < 4; r++) begin
			a = $random(seed);
			b = $random(seed);
			clr();
			pulse(0, ctl_word(1, 1, 0, r[0], 0, r[1:0]));
			u_spc_far_end.slave_load(b);
			pulse(2, a);
			wait_idle();
			u_spc_far_end.slave_stop();
			check("master sent", u_spc_far_end.slv_rx, a);
			check("master got", o_rx_data, b);
			check("sck period", 8'(u_spc_far_end.edge_gap), 8'(2 << r));
			check("master irq", 8'(irq_cnt), 8'(r % 2));
			check("master avail", {7'h0, u_spc_port.o_rx_avail}, 8'h01);
			pulse(3, 8'h00);
			check("avail after read", {7'h0, u_spc_port.o_rx_avail}, 8'h00);
		end
		$display("test master rates done");
		// Master clocked from the timer: one divider tick per timer rise.
		clr();
		pulse(0, ctl_word(1, 1, 0, 0, 0, 2'h0) | (8'h01 << CTL_CLKSRC_BIT));
		u_spc_far_end.slave_load(b);
		pulse(2, a);
		wait_idle();
		u_spc_far_end.slave_stop();
		check("timer sent", u_spc_far_end.slv_rx, a);
		check("timer got", o_rx_data, b);
		check("timer period", 8'(u_spc_far_end.edge_gap), 8'h04);
		pulse(3, 8'h00);
		$display("test timer clock done");
		// Slave, phase 0: echo of a preloaded byte, then a second byte over the unread first.
		a = $random(seed);
		b = $random(seed);
		clr();
		pulse(0, ctl_word(1, 0, 0, 1, 0, 2'h0));
		pulse(2, 8'h3C);
		u_spc_far_end.sel(1'b0);
		u_spc_far_end.master_byte(1'b0, a, got);
		repeat (2) @(negedge i_sys_clk);
		check("slave rx", o_rx_data, a);
		check("slave echo", got, 8'h3C);
		check("slave irq", 8'(irq_cnt), 8'h01);
		check("slave sck oe", {7'h0, o_serial_clock_pin_oe}, 8'h00);
		u_spc_far_end.master_byte(1'b0, b, got);
		u_spc_far_end.desel();
		check("overwrite", o_rx_data, b);
		check("overrun", {7'h0, o_ctl_rdata[CTL_OVR_RATE_LO]}, 8'h01);
		pulse(3, 8'h00);
		check("overrun kept", {7'h0, o_ctl_rdata[CTL_OVR_RATE_LO]}, 8'h01);
		pulse(0, ctl_word(1, 0, 0, 1, 0, 2'h0));
		check("overrun cleared", {7'h0, o_ctl_rdata[CTL_OVR_RATE_LO]}, 8'h00);
		$display("test slave overrun done");
		// Slave, phase 1, data output muted by bit 2: sampled on the falling edge.
		pulse(0, ctl_word(1, 0, 1, 0, 0, 2'h2));
		clr();
		for (int k = 0; k < 3; k++) begin
			a = $random(seed);
			u_spc_far_end.sel(1'b1);
			u_spc_far_end.master_byte(1'b1, a, got);
			u_spc_far_end.desel();
			check("phase one rx", o_rx_data, a);
			pulse(3, 8'h00);
		end
		check("muted output", {7'h0, oe_seen}, 8'h00);
		$display("test phase done");
		// Compare: a match wakes and opens the output, a mismatch mutes until deselect.
		a = $random(seed);
		b = $random(seed);
		pulse(0, ctl_word(1, 0, 0, 1, 1, 2'h0));
		pulse(1, a);
		clr();
		u_spc_far_end.oe_bits = 0;
		u_spc_far_end.sel(1'b0);
		u_spc_far_end.master_byte(1'b0, a, got);
		repeat (2) @(negedge i_sys_clk);
		check("compare silent", 8'(u_spc_far_end.oe_bits), 8'h00);
		check("compare no irq", 8'(irq_cnt), 8'h00);
		check("match wake", 8'(wake_cnt), 8'h01);
		u_spc_far_end.master_byte(1'b0, b, got);
		u_spc_far_end.desel();
		check("after match rx", o_rx_data, b);
		check("after match oe", {7'h0, oe_seen}, 8'h01);
		pulse(3, 8'h00);
		clr();
		u_spc_far_end.sel(1'b0);
		u_spc_far_end.master_byte(1'b0, a ^ 8'h01, got);
		u_spc_far_end.master_byte(1'b0, ~b, got);
		u_spc_far_end.desel();
		check("mismatch wake", 8'(wake_cnt), 8'h00);
		check("mismatch irq", 8'(irq_cnt), 8'h00);
		check("mismatch oe", {7'h0, oe_seen}, 8'h00);
		check("mismatch avail", {7'h0, u_spc_port.o_rx_avail}, 8'h00);
		$display("test compare done");
		// FIFO: fill past 16 with the drain stalled, then drain in order.
		pulse(0, ctl_word(1, 0, 0, 0, 0, 2'h0));
		@(negedge i_sys_clk);
		i_fifo_ready = 1'b0;
		u_spc_far_end.sel(1'b0);
		for (int k = 0; k <= FIFO_DEPTH; k++) begin
			a = $random(seed);
			q.push_back(a);
			u_spc_far_end.master_byte(1'b0, a, got);
		end
		u_spc_far_end.desel();
		for (int k = 0; k < FIFO_DEPTH; k++) begin
			@(negedge i_sys_clk);
			check("fifo valid", {7'h0, o_fifo_valid}, 8'h01);
			check("fifo data", o_fifo_data, q[k]);
			i_fifo_ready = 1'b1;
			@(negedge i_sys_clk);
			i_fifo_ready = 1'b0;
		end
		@(negedge i_sys_clk);
		check("fifo empty", {7'h0, o_fifo_valid}, 8'h00);
		$display("test fifo done");
		complete_run();
	end
endmodule // test_spi_master_slave_compare
